// [core/fsso_top.sv]
// Functional notes
// R1: Each transfer sends exactly its bit count, from 1 to 16 bits.
// R2: The data line becomes a driven output when a transfer starts.
// R3: Requester sets the clock idle level first; engine rests there.
// R4: Each bit: data placed first, then clock toggles away and back.
// R5: Flag bit 0 clear sends MSB first, set sends LSB first.
// R6: MSB-first short transfers take their bits from the upper bits.
// R7: LSB-first short transfers take their bits from the lower bits.
// R8: Flag bit 2 paces each bit by the period, else fastest rate.
// R9: Period counts clock cycles, slowed by the prescale setting.
// R10: A zero period shifts at the fastest rate even when paced.
// R11: Requester keeps paced periods at or above about 60 cycles.
// R12: Fast mode bit takes 32 cycles, active phase 8 of them.
// R13: Paced mode keeps the clock duty cycle near half.
// R14: Flag bit 3 clear drives the data line high and low.
// R15: Flag bit 3 set releases for one, drives low for zero.
// R16: Requester keeps flag bits other than 0, 2 and 3 at zero.
// R17: Pacing timer claimed only when paced; if owned, abort at once.
// R18: Interrupts masked while busy; clock ticks are held, not lost; the code holds at most 15 and drops any further tick.
// R19: Busy during the transfer; done after clock returns to rest.
//
// Implementation choices: the plain strobed port and the placing of the registers.
module fsso_top
  import fsso_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdata,
  output logic reqReady,
  output logic serialOut,
  output logic serialOutEn_n,
  output logic shiftClockLine,
  input wire logic timerBusy,
  output logic timerClaim,
  output logic irqMask,
  input wire logic rtcTickIn,
  output logic rtcTickOut,
  output logic busy,
  output logic done
);

  localparam int REQ_W = $bits(fsso_req_t);

  fsso_state_t state;
  fsso_req_t cur;
  fsso_req_t newReq;
  fsso_req_t headReq;
  logic [7:0] flags;
  logic [CNT_W-1:0] bitCount;
  logic [DATA_W-1:0] bitPeriod;
  logic [PRE_W-1:0] pacingPrescale;
  logic clockIdle;
  logic curIdle;
  logic [DATA_W-1:0] lastData;
  logic aborted;
  logic curAbort;
  logic [DATA_W-1:0] shreg;
  logic [DATA_W-1:0] shifted;
  logic [CNT_W-1:0] bitsLeft;
  logic [15:0] phaseLeft;
  logic [RTC_ACC_W-1:0] rtcPending;
  logic headValid;
  logic popFire;
  logic abortNow;
  logic effFast;
  logic tick;
  logic step;
  logic phaseDone;
  logic pushValid;
  logic fifoEmpty;

  function automatic logic [15:0] phaseLen(input logic paced,
                                           input logic [15:0] per,
                                           input logic act);
    logic fast;
    fast = !paced || (per == 16'h0000); // R10
    if (fast)
      phaseLen = act ? FAST_ACT_CYC : FAST_LEAD_CYC; // R12
    else
      phaseLen = act ? per - (per >> 1) : per >> 1; // R13
  endfunction

  function automatic logic firstBit(input logic lsb,
                                    input logic [DATA_W-1:0] d);
    firstBit = lsb ? d[0] : d[DATA_W-1]; // R5
  endfunction

  // Snapshot of the flags, count and period travels with each data word; prescale and clock idle level are not captured
  assign newReq.lsbFirst = flags[FLAG_LSB];
  assign newReq.paced = flags[FLAG_PACED];
  assign newReq.openDrain = flags[FLAG_OD];
  assign newReq.count = bitCount;
  assign newReq.period = bitPeriod;
  assign newReq.data = regWdata;
  assign pushValid = regWrite && (regAddr == REG_DATA);

  fsso_fifo #(
    .W(REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .inData(newReq),
    .inValid(pushValid),
    .inReady(reqReady),
    .outData(headReq),
    .outValid(headValid),
    .outReady(state == ST_IDLE)
  );

  assign fifoEmpty = !headValid;
  assign popFire = headValid && (state == ST_IDLE);
  assign abortNow = headReq.paced && timerBusy; // R17
  assign effFast = !cur.paced || (cur.period == 16'h0000); // R8 R10
  assign step = effFast ? 1'b1 : tick; // R9
  assign phaseDone = step && (phaseLeft == 16'h0001);
  assign shifted = cur.lsbFirst ? shreg >> 1 : shreg << 1; // R5
  assign busy = state != ST_IDLE; // R19
  assign done = state == ST_FINISH; // R19
  assign irqMask = busy; // R18

  fsso_pacer u_pacer (
    .clk(clk),
    .reset_n(reset_n),
    .run(busy && !effFast),
    .prescale(pacingPrescale),
    .tick(tick)
  );

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state <= ST_IDLE;
      cur <= '0;
      curIdle <= 1'b0;
      curAbort <= 1'b0;
      shreg <= '0;
      bitsLeft <= '0;
      phaseLeft <= '0;
      shiftClockLine <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          shiftClockLine <= clockIdle; // R3
          if (popFire)
          begin
            cur <= headReq;
            curIdle <= clockIdle; // R3
            curAbort <= abortNow;
            shreg <= headReq.data;
            bitsLeft <= headReq.count; // R1
            phaseLeft <= phaseLen(headReq.paced, headReq.period, 1'b0);
            state <= abortNow ? ST_FINISH : ST_SETUP; // R17
          end
        end
        ST_SETUP:
        begin
          phaseLeft <= phaseDone ? phaseLen(cur.paced, cur.period, 1'b1)
                                 : phaseLeft - {15'h0000, step};
          if (phaseDone)
          begin
            shiftClockLine <= !curIdle; // R4
            state <= ST_ACTIVE;
          end
        end
        ST_ACTIVE:
        begin
          phaseLeft <= phaseDone ? phaseLen(cur.paced, cur.period, 1'b0)
                                 : phaseLeft - {15'h0000, step};
          if (phaseDone)
          begin
            shiftClockLine <= curIdle; // R4
            shreg <= shifted;
            bitsLeft <= bitsLeft - 1'b1; // R1
            state <= (bitsLeft == COUNT_MIN) ? ST_FINISH : ST_SETUP;
          end
        end
        ST_FINISH:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Data line keeps its last drive between transfers, like a port pin
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      serialOut <= 1'b0;
      serialOutEn_n <= 1'b1;
    end
    else if (popFire && !abortNow)
    begin
      serialOut <= !headReq.openDrain &&
                   firstBit(headReq.lsbFirst, headReq.data); // R2 R14
      serialOutEn_n <= headReq.openDrain &&
                       firstBit(headReq.lsbFirst, headReq.data); // R15
    end
    else if (state == ST_ACTIVE && phaseDone && bitsLeft != COUNT_MIN)
    begin
      serialOut <= !cur.openDrain &&
                   firstBit(cur.lsbFirst, shifted); // R4 R14
      serialOutEn_n <= cur.openDrain &&
                       firstBit(cur.lsbFirst, shifted); // R15
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      timerClaim <= 1'b0;
    end
    else if (popFire && headReq.paced && !timerBusy)
    begin
      timerClaim <= 1'b1; // R17
    end
    else if (state == ST_FINISH)
    begin
      timerClaim <= 1'b0;
    end
  end

  // Held ticks drain one per cycle once the transfer ends
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rtcPending <= '0;
      rtcTickOut <= 1'b0;
    end
    // A tick launched on a pop edge would land inside the next transfer
    else if (busy || popFire)
    begin
      rtcTickOut <= 1'b0;
      if (rtcTickIn && rtcPending != '1)
        rtcPending <= rtcPending + 1'b1; // R18
    end
    else
    begin
      rtcTickOut <= rtcTickIn || (rtcPending != '0);
      if (!rtcTickIn && rtcPending != '0)
        rtcPending <= rtcPending - 1'b1; // R18
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      flags <= FLAGS_RST;
      bitCount <= COUNT_RST;
      bitPeriod <= '0;
      pacingPrescale <= PRESCALE_RST;
      clockIdle <= 1'b0;
      lastData <= '0;
    end
    else if (regWrite)
    begin
      unique case (regAddr)
        REG_FLAGS: flags <= regWdata[7:0];
        REG_COUNT:
        begin
          // Out-of-range counts are clamped into 1..16
          if (regWdata == '0)
            bitCount <= COUNT_MIN; // R1
          else if (regWdata > {11'h000, COUNT_MAX})
            bitCount <= COUNT_MAX; // R1
          else
            bitCount <= regWdata[CNT_W-1:0];
        end
        REG_PERIOD: bitPeriod <= regWdata;
        REG_PRESCALE: pacingPrescale <= regWdata[PRE_W-1:0]; // R9
        REG_CLKIDLE: clockIdle <= regWdata[0];
        REG_DATA: lastData <= regWdata;
        default:
        begin
        end
      endcase
    end
  end

  // Abort flag: a new abort beats a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      aborted <= 1'b0;
    else if (popFire && abortNow)
      aborted <= 1'b1;
    else if (regWrite && regAddr == REG_STATUS && regWdata[STAT_ABORT])
      aborted <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n || !regRead)
      regRdata <= '0;
    else
    begin
      unique case (regAddr)
        REG_FLAGS: regRdata <= {8'h00, flags};
        REG_COUNT: regRdata <= {11'h000, bitCount};
        REG_PERIOD: regRdata <= bitPeriod;
        REG_PRESCALE: regRdata <= {8'h00, pacingPrescale};
        REG_CLKIDLE: regRdata <= {15'h0000, clockIdle};
        REG_DATA: regRdata <= lastData;
        REG_STATUS: regRdata <= {12'h000, aborted, fifoEmpty,
                                 reqReady, busy};
        default: regRdata <= '0;
      endcase
    end
  end

  // Helper: clock pulses sent in the current transfer
  logic [CNT_W-1:0] pulseCnt;
  always_ff @(posedge clk)
  begin
    if (!reset_n || popFire)
      pulseCnt <= '0;
    else if (state == ST_SETUP && phaseDone)
      pulseCnt <= pulseCnt + 1'b1;
  end

  property p_count;
    @(posedge clk) disable iff (!reset_n)
    done && !curAbort |-> pulseCnt == cur.count;
  endproperty
  a_count: assert property (p_count) // R1
    else $error("bit count mismatch");

  property p_drive;
    @(posedge clk) disable iff (!reset_n)
    popFire && !abortNow && !headReq.openDrain |=> !serialOutEn_n;
  endproperty
  a_drive: assert property (p_drive) // R2
    else $error("data line not driven at start");

  property p_setup;
    @(posedge clk) disable iff (!reset_n)
    busy && shiftClockLine != curIdle |-> $stable(serialOut);
  endproperty
  a_setup: assert property (p_setup) // R4
    else $error("data changed during clock pulse");

  property p_order;
    @(posedge clk) disable iff (!reset_n)
    popFire && !abortNow && !headReq.openDrain |=>
      serialOut == (cur.lsbFirst ? cur.data[0] : cur.data[DATA_W-1]);
  endproperty
  a_order: assert property (p_order) // R5
    else $error("wrong first bit");

  property p_fast;
    @(posedge clk) disable iff (!reset_n)
    $rose(state == ST_ACTIVE) && effFast |->
      (state == ST_ACTIVE)[*8] ##1 (state != ST_ACTIVE);
  endproperty
  a_fast: assert property (p_fast) // R12
    else $error("fast active phase not 8 cycles");

  property p_zero;
    @(posedge clk) disable iff (!reset_n)
    $rose(state == ST_SETUP) && cur.paced && cur.period == 16'h0000
      |-> !timerBusy || timerClaim ##0 phaseLeft == FAST_LEAD_CYC;
  endproperty
  a_zero: assert property (p_zero) // R10
    else $error("zero period not fast");

  property p_duty;
    @(posedge clk) disable iff (!reset_n)
    $rose(state == ST_ACTIVE) && !effFast |->
      phaseLeft == cur.period - (cur.period >> 1);
  endproperty
  a_duty: assert property (p_duty) // R13
    else $error("paced active phase wrong");

  property p_odrain;
    @(posedge clk) disable iff (!reset_n)
    busy && cur.openDrain && !$rose(busy) |-> !serialOut;
  endproperty
  a_odrain: assert property (p_odrain) // R15
    else $error("open drain drove high");

  property p_abort;
    @(posedge clk) disable iff (!reset_n)
    popFire && abortNow |=> done && !timerClaim ##1 aborted && !busy;
  endproperty
  a_abort: assert property (p_abort) // R17
    else $error("busy timer not aborted");

  property p_rtc;
    @(posedge clk) disable iff (!reset_n)
    busy && rtcTickIn && rtcPending == '0 |=> rtcPending != '0;
  endproperty
  a_rtc: assert property (p_rtc) // R18
    else $error("tick lost while masked");

  property p_quiet;
    @(posedge clk) disable iff (!reset_n)
    busy |-> !rtcTickOut;
  endproperty
  a_quiet: assert property (p_quiet) // R18
    else $error("tick passed while masked");

  property p_done;
    @(posedge clk) disable iff (!reset_n)
    done |-> shiftClockLine == curIdle ##1 !busy;
  endproperty
  a_done: assert property (p_done) // R19
    else $error("done before clock at rest");

  c_fast: cover property (@(posedge clk) done && !cur.paced && !curAbort);
  c_paced: cover property (@(posedge clk) done && !effFast && !curAbort);
  c_abort: cover property (@(posedge clk) popFire && abortNow);
  c_full: cover property (@(posedge clk) !reqReady);

endmodule

// [core/fsso_pkg.sv]
package fsso_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam int CNT_W = 5;
  localparam int PRE_W = 8;
  localparam int RTC_ACC_W = 4;
  localparam int FIFO_DEPTH = 4;

  // Register indices on the plain register port
  localparam logic [ADDR_W-1:0] REG_FLAGS = 3'h0;
  localparam logic [ADDR_W-1:0] REG_COUNT = 3'h1;
  localparam logic [ADDR_W-1:0] REG_PERIOD = 3'h2;
  localparam logic [ADDR_W-1:0] REG_PRESCALE = 3'h3;
  localparam logic [ADDR_W-1:0] REG_CLKIDLE = 3'h4;
  localparam logic [ADDR_W-1:0] REG_DATA = 3'h5;
  localparam logic [ADDR_W-1:0] REG_STATUS = 3'h6;

  // Flag bit positions
  localparam int FLAG_LSB = 0;
  localparam int FLAG_PACED = 2;
  localparam int FLAG_OD = 3;

  // Status bit positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_READY = 1;
  localparam int STAT_EMPTY = 2;
  localparam int STAT_ABORT = 3;

  // Reset values and count limits
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_RST = 5'h10;
  localparam logic [CNT_W-1:0] COUNT_MIN = 5'h01;
  localparam logic [CNT_W-1:0] COUNT_MAX = 5'h10;
  localparam logic [PRE_W-1:0] PRESCALE_RST = 8'h01;

  // Fast mode bit timing in clock cycles
  localparam logic [15:0] FAST_BIT_CYC = 16'h0020;
  localparam logic [15:0] FAST_ACT_CYC = 16'h0008;
  localparam logic [15:0] FAST_LEAD_CYC = FAST_BIT_CYC - FAST_ACT_CYC;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_ACTIVE = 4'b0100,
    ST_FINISH = 4'b1000
  } fsso_state_t;

  typedef struct packed {
    logic lsbFirst;
    logic paced;
    logic openDrain;
    logic [CNT_W-1:0] count;
    logic [DATA_W-1:0] period;
    logic [DATA_W-1:0] data;
  } fsso_req_t;

endpackage

// [core/fsso_fifo.sv]
module fsso_fifo
  import fsso_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = 4
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [W-1:0] outData,
  output logic outValid,
  input wire logic outReady
);

  // Depth must be a power of two; the pointers wrap naturally
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;
  logic full;
  logic empty;

  assign empty = wrPtr == rdPtr;
  assign full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (inValid && !full)
    begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wrPtr <= '0;
    end
    else if (inValid && !full)
    begin
      wrPtr <= wrPtr + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rdPtr <= '0;
    end
    else if (outReady && !empty)
    begin
      rdPtr <= rdPtr + 1'b1;
    end
  end

endmodule

// [core/fsso_pacer.sv]
module fsso_pacer
  import fsso_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [PRE_W-1:0] prescale,
  output logic tick
);

  logic [PRE_W-1:0] cnt;
  logic [PRE_W-1:0] lastCnt;

  // A prescale of zero behaves as one, so pacing never stalls
  assign lastCnt = (prescale == '0) ? '0 : prescale - 1'b1;
  assign tick = run && (cnt >= lastCnt);

  always_ff @(posedge clk)
  begin
    if (!reset_n || !run || tick)
    begin
      cnt <= '0;
    end
    else
    begin
      cnt <= cnt + 1'b1;
    end
  end

endmodule

// [verif/fsso_sink_model.sv]
module fsso_sink_model
(
  input wire logic clk,
  input wire logic dataLevel,
  input wire logic clockLine,
  input wire logic idleLevel,
  output logic [15:0] shiftReg,
  output logic [15:0] bitTotal,
  output logic [15:0] actCyc,
  output logic [15:0] holdErr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prevClk;
  logic prevData;

  initial
  begin
    prevClk = 1'b0;
    prevData = 1'b1;
    shiftReg = 16'h0000;
    bitTotal = 16'h0000;
    actCyc = 16'h0000;
    holdErr = 16'h0000;
  end

  // Sampled on the system clock, so edges a cycle apart are seen
  always @(posedge clk)
  begin
    prevClk <= clockLine;
    prevData <= dataLevel;
    if (prevClk == idleLevel && clockLine != idleLevel)
    begin
      shiftReg <= {shiftReg[14:0], dataLevel};
      bitTotal <= bitTotal + 16'h0001;
      actCyc <= 16'h0001;
      if (dataLevel != prevData)
        holdErr <= holdErr + 16'h0001;
    end
    else if (clockLine != idleLevel)
    begin
      actCyc <= actCyc + 16'h0001;
      if (dataLevel != prevData)
        holdErr <= holdErr + 16'h0001;
    end
  end
endmodule

// [verif/fsso_top_tb_top.sv]
module fsso_top_tb_top
  import fsso_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, regWrite, regRead, timerBusy, rtcTickIn, clkIdle;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata;
  logic reqReady, serialOut, serialOutEn_n, shiftClockLine, timerClaim;
  logic irqMask, rtcTickOut, busy, done, dataLevel;
  logic [15:0] shiftReg, bitTotal, actCyc, holdErr;
  int cyc, busyTotal, doneTotal, rtcOutTotal, rtcOutBusy, irqBad, claimTotal;
  int n_fail, n_compared;

  // Released line floats up through the pull-up
  assign dataLevel = serialOutEn_n ? 1'b1 : serialOut;

  fsso_top uut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .reqReady(reqReady), .serialOut(serialOut),
    .serialOutEn_n(serialOutEn_n), .shiftClockLine(shiftClockLine),
    .timerBusy(timerBusy), .timerClaim(timerClaim), .irqMask(irqMask),
    .rtcTickIn(rtcTickIn), .rtcTickOut(rtcTickOut), .busy(busy),
    .done(done));

  fsso_sink_model sink (.clk(clk), .dataLevel(dataLevel),
    .clockLine(shiftClockLine), .idleLevel(clkIdle), .shiftReg(shiftReg),
    .bitTotal(bitTotal), .actCyc(actCyc), .holdErr(holdErr));

  always #10 clk = ~clk;

  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Nonblocking so readers after an edge see one consistent snapshot
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (busy === 1'b1)
      busyTotal <= busyTotal + 1;
    if (done === 1'b1)
      doneTotal <= doneTotal + 1;
    if (rtcTickOut === 1'b1)
      rtcOutTotal <= rtcOutTotal + 1;
    if (rtcTickOut === 1'b1 && busy === 1'b1)
      rtcOutBusy <= rtcOutBusy + 1;
    if (irqMask !== busy)
      irqBad <= irqBad + 1;
    if (timerClaim === 1'b1)
      claimTotal <= claimTotal + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    regRead <= 1'b0;
    @(posedge clk);
  endtask

  task automatic idle();
    regWrite <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    regWrite <= 1'b0;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    chk("regRdata", e, regRdata);
  endtask

  task automatic setIdle(input logic v);
    clkIdle <= v;
    wr(REG_CLKIDLE, {15'h0000, v});
  endtask

  function automatic logic [15:0] expBits(input logic [15:0] d,
                                          input int n, input logic lsb);
    logic [15:0] e;
    e = 16'h0000;
    for (int i = 0; i < n; i++)
      e = {e[14:0], lsb ? d[i] : d[15-i]};
    return e;
  endfunction

  task automatic run(input string nm, input logic [7:0] f,
                     input logic [15:0] n, per, d, eb, lo, hi, aLo, aHi);
    int c0, d0, k, w;
    logic [15:0] b0, m;
    b0 = bitTotal;
    c0 = busyTotal;
    d0 = doneTotal;
    wr(REG_FLAGS, {8'h00, f});
    wr(REG_COUNT, n);
    wr(REG_PERIOD, per);
    wr(REG_DATA, d);
    idle();
    for (k = 0; k < 3000 && doneTotal == d0; k++)
      @(posedge clk);
    w = busyTotal - c0;
    m = (eb == 16'h0010) ? 16'hffff : (16'h0001 << eb) - 16'h0001;
    chk("bitCount", eb, bitTotal - b0);
    chk("shifted", expBits(d, int'(eb), f[FLAG_LSB]) & m, shiftReg & m);
    chk("busyWindow", 16'h0001, {15'h0000, w >= lo && w <= hi});
    if (eb != 16'h0000)
      chk("actCyc", 16'h0001, {15'h0000, actCyc inside {[aLo:aHi]}});
    $display("Test %s finished", nm);
  endtask

  initial
  begin
    int c0, d0, r0, rb, b0, k;
    clk = 1'b0;
    reset_n = 1'b0;
    regAddr = '0;
    regWdata = '0;
    regWrite = 1'b0;
    regRead = 1'b0;
    timerBusy = 1'b0;
    rtcTickIn = 1'b0;
    clkIdle = 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(REG_FLAGS, 16'h0000);
    rd(REG_COUNT, 16'h0010);
    rd(REG_PERIOD, 16'h0000);
    rd(REG_PRESCALE, 16'h0001);
    rd(REG_STATUS, 16'h0006);
    wr(3'h7, 16'h5a5a);
    wr(REG_COUNT, 16'h0000);
    rd(3'h7, 16'h0000);
    rd(REG_COUNT, 16'h0001);
    wr(REG_COUNT, 16'h0014);
    rd(REG_COUNT, 16'h0010);
    $display("Test registers finished");
    // Fast transfers must ignore a busy shared timer
    timerBusy <= 1'b1;
    c0 = claimTotal;
    run("fastMsb16", 8'h00, 16'h0010, 16'h0000, 16'ha5c3, 16'h0010,
        16'd513, 16'd513, 16'h0008, 16'h0008);
    chk("serialOutEn_n", 16'h0000, {15'h0000, serialOutEn_n});
    setIdle(1'b1);
    run("lsbOpenDrain", 8'h09, 16'h0005, 16'h0000, 16'h0016, 16'h0005,
        16'd161, 16'd161, 16'h0008, 16'h0008);
    chk("fastClaim", 16'h0000, 16'(claimTotal - c0));
    timerBusy <= 1'b0;
    setIdle(1'b0);
    c0 = claimTotal;
    run("paced64", 8'h04, 16'h0003, 16'd64, 16'he000, 16'h0003,
        16'd193, 16'd200, 16'd30, 16'd34);
    chk("pacedClaim", 16'h0001, {15'h0000, claimTotal != c0});
    run("pacedZero", 8'h04, 16'h0002, 16'h0000, 16'h8000, 16'h0002,
        16'd65, 16'd68, 16'h0008, 16'h0008);
    wr(REG_PRESCALE, 16'h0002);
    run("prescale2", 8'h04, 16'h0001, 16'd64, 16'h8000, 16'h0001,
        16'd129, 16'd136, 16'd62, 16'd68);
    wr(REG_PRESCALE, 16'h0001);
    timerBusy <= 1'b1;
    run("abort", 8'h04, 16'h0004, 16'd64, 16'hf000, 16'h0000,
        16'h0001, 16'h0001, 16'h0000, 16'hffff);
    rd(REG_STATUS, 16'h000e);
    wr(REG_STATUS, 16'h0008);
    rd(REG_STATUS, 16'h0006);
    timerBusy <= 1'b0;
    // Sixth request finds the buffer full and is dropped
    wr(REG_COUNT, 16'h0001);
    wr(REG_FLAGS, 16'h0000);
    d0 = doneTotal;
    b0 = bitTotal;
    r0 = rtcOutTotal;
    rb = rtcOutBusy;
    for (k = 0; k < 6; k++)
      wr(REG_DATA, 16'h8000);
    rd(REG_STATUS, 16'h0001);
    chk("reqReady", 16'h0000, {15'h0000, reqReady});
    repeat (3)
    begin
      rtcTickIn <= 1'b1;
      @(posedge clk);
      rtcTickIn <= 1'b0;
      @(posedge clk);
    end
    for (k = 0; k < 1000 && doneTotal - d0 < 5; k++)
      @(posedge clk);
    repeat (40) @(posedge clk);
    chk("doneCount", 16'h0005, 16'(doneTotal - d0));
    chk("fifoBits", 16'h0005, 16'(bitTotal - b0));
    chk("rtcWhileBusy", 16'h0000, 16'(rtcOutBusy - rb));
    chk("rtcTotal", 16'h0003, 16'(rtcOutTotal - r0));
    chk("irqMask", 16'h0000, 16'(irqBad));
    chk("dataHold", 16'h0000, holdErr);
    rd(REG_STATUS, 16'h0006);
    $display("Test fifoAndTicks finished");
    stop_test();
  end
endmodule
